// file: src/adc_serial_pkg.sv
// constants shared by the converter serial control port and its buffer
package adc_serial_pkg;
	localparam int          RES_W        = 10;      // result width
	localparam int          ADDR_W       = 4;       // channel address width
	localparam int          MUX_N        = 14;      // multiplexer inputs
	localparam int          EXT_N        = 11;      // external inputs
	localparam logic [4:0]  ADDR_RISES   = 5'h04;   // rises that load address
	localparam logic [4:0]  SAMPLE_FALL  = 5'h04;   // fall that opens sampling
	localparam logic [4:0]  CONV_FALL    = 5'h0A;   // fall that starts convert
	localparam logic [4:0]  SLOW_RISE    = 5'h0B;   // rise that marks slow mode
	localparam logic [4:0]  MAX_CLKS     = 5'h10;   // longest transfer
	localparam logic [3:0]  LAST_SHIFT   = 4'h8;    // bit index after msb
	localparam logic [3:0]  ADDR_MID_REF = 4'hB;    // mid-reference test code
	localparam logic [3:0]  ADDR_LO_REF  = 4'hC;    // low-reference test code
	localparam logic [3:0]  ADDR_HI_REF  = 4'hD;    // high-reference test code
	localparam logic [1:0]  BUF_DEPTH    = 2'h2;    // result buffer entries
	localparam logic        EOC_RESET    = 1'h1;    // idle level of done flag

	// conversion progress, one-hot
	typedef enum logic [2:0] {
		CV_IDLE = 3'b001,
		CV_BUSY = 3'b010,
		CV_SLOW = 3'b100
	} conv_e;
endpackage

// file: src/stream_if.sv
// valid/ready word stream between the port logic and its buffer
`timescale 1ns/1ps
interface stream_if #(parameter int W = 10);
	logic         valid;  // word offered
	logic         ready;  // word accepted
	logic [W-1:0] data;   // word

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// file: src/result_buffer.sv
// two-entry result buffer; read data come straight from the head register
`timescale 1ns/1ps
module result_buffer
	import adc_serial_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic rst,
	stream_if.snk     inS,
	stream_if.src     outS
);
	logic [RES_W-1:0] head;       // oldest word, drives outS.data
	logic [RES_W-1:0] tail;       // second word
	logic [1:0]       cnt;        // words held
	logic [1:0]       next_cnt;   // words after this cycle
	logic             inRdy;      // registered room flag
	logic             outVal;     // registered presence flag
	logic             push;       // accepted write
	logic             pop;        // accepted read

	assign push      = inS.valid && inRdy;
	assign pop       = outVal && outS.ready;
	assign inS.ready = inRdy;
	assign outS.valid = outVal;
	assign outS.data  = head;

	// occupancy after this cycle
	always_comb begin
		next_cnt = cnt;
		if (push && !pop)
			next_cnt = cnt + 2'h1;
		else if (pop && !push)
			next_cnt = cnt - 2'h1;
	end

	// flags are registered so the top sees flop outputs only
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cnt    <= 2'h0;
			inRdy  <= 1'b1;
			outVal <= 1'b0;
		end else begin
			cnt    <= next_cnt;
			inRdy  <= next_cnt != BUF_DEPTH;
			outVal <= next_cnt != 2'h0;
		end
	end

	// storage moves forward on a read; a write fills the first free slot
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			head <= '0;
			tail <= '0;
		end else begin
			if (pop)
				head <= (cnt == BUF_DEPTH) ? tail : inS.data;
			else if (push && cnt == 2'h0)
				head <= inS.data;
			if (push && (cnt == BUF_DEPTH || (cnt == 2'h1 && !pop)))
				tail <= inS.data;
		end
	end

	a_buf_no_overrun : assert property ( // R18
		@(posedge clk_sys) disable iff (rst)
		cnt == BUF_DEPTH |-> !inRdy)
		else $error("buffer offers room while full");
endmodule

// file: src/serial_adc_control_port.sv
// serial control, sample timing and result shift logic of the converter
//
// Functional notes
// R01 - done output low at 10th fall, high later
// R02 - first four rises load address register
// R03 - sampling from 4th fall to 10th fall
// R04 - 10th fall hands conversion to core
// R05 - select high: inputs ignored, output floats
// R06 - select low: inputs enabled, output driven
// R07 - host clocks 10 to 16, reads result
// R08 - msb timing depends on transfer mode
// R09 - nine more bits on following falls
// R10 - conversion never starts before ten clocks
// R11 - 10th fall forces output low
// R12 - six host modes, 10 to 16 clocks
// R13 - transfer ending before result is fast
// R14 - address arrives msb first
// R15 - select fall clears counters and control
// R16 - codes 0-A external, B-D self test
// R17 - slow mode needs 11th rise early
// R18 - each result latched for next transfer
`timescale 1ns/1ps
module serial_adc_control_port
	import adc_serial_pkg::*;
(
	input  wire logic             clk_sys,
	input  wire logic             rst,
	input  wire logic             csN,
	input  wire logic             ioClk,
	input  wire logic             addrIn,
	output logic                  dataOut,
	output logic                  dataOutEn,
	output logic                  eoc,
	output logic [MUX_N-1:0]      muxSel,
	output logic                  sampling,
	output logic                  convStart,
	input  wire logic             coreValid,
	input  wire logic [RES_W-1:0] coreData,
	output logic                  coreReady
);
	logic              csM;        // select, first sync stage
	logic              csS;        // select, synchronised
	logic              csD;        // select, delayed for edges
	logic              clkM;       // shift clock, first sync stage
	logic              clkS;       // shift clock, synchronised
	logic              clkD;       // shift clock, delayed for edges
	logic              adM;        // address, first sync stage
	logic              adS;        // address, synchronised
	logic              csFallEv;   // select just went low
	logic              fallEv;     // shift clock fell, select low
	logic              riseEv;     // shift clock rose, select low
	logic [4:0]        fallCnt;    // falls since sequence start
	logic [4:0]        riseCnt;    // rises since sequence start
	logic [ADDR_W-2:0] addrShift;  // address bits gathered so far
	logic [ADDR_W-1:0] chSel;      // captured channel address
	logic [RES_W-1:0]  resHold;    // result being shown to the host
	logic [3:0]        bitIdx;     // result bit for the next fall
	logic              nextBit;    // that bit
	logic              popOk;      // result may leave the buffer now
	logic              pop;        // result leaves the buffer
	logic              restart;    // new sequence while select stays low
	logic              tenthFall;  // fall that ends sampling
	conv_e             convState;  // conversion progress

	stream_if #(.W(RES_W)) inS ();
	stream_if #(.W(RES_W)) outS ();

	// core results queue here so a busy shifter never drops one
	result_buffer u_buf (
		.clk_sys (clk_sys),
		.rst     (rst),
		.inS     (inS),
		.outS    (outS)
	);

	assign inS.valid  = coreValid;
	assign inS.data   = coreData;
	assign coreReady  = inS.ready;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	// pins come from the host domain; two stages before any use
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			csM  <= 1'b1;
			csS  <= 1'b1;
			csD  <= 1'b1;
			clkM <= 1'b0;
			clkS <= 1'b0;
			clkD <= 1'b0;
			adM  <= 1'b0;
			adS  <= 1'b0;
		end else begin
			csM  <= csN;
			csS  <= csM;
			csD  <= csS;
			clkM <= ioClk;
			clkS <= clkM;
			clkD <= clkS;
			adM  <= addrIn;
			adS  <= adM;
		end
	end

	// clock and address are only looked at while select is low
	assign csFallEv  = csD && !csS;
	assign fallEv    = !csS && clkD && !clkS; // R05
	assign riseEv    = !csS && !clkD && clkS; // R05
	assign tenthFall = fallEv && fallCnt == CONV_FALL - 5'h01;
	assign bitIdx    = LAST_SHIFT - fallCnt[3:0];
	assign nextBit   = resHold[bitIdx];

	// a waiting result is shown at once when select is high or the
	// transfer is past its tenth fall; a slow transfer keeps it back
	// until the sixteenth fall so the bits in flight are not cut
	assign popOk = csS
		|| (fallCnt >= CONV_FALL
		&& (convState != CV_SLOW || fallCnt == MAX_CLKS)); // R08 R13
	assign pop        = outS.valid && popOk;
	assign outS.ready = popOk;
	assign restart    = pop && !csS;

	// edge counters; they saturate so extra clocks do no harm
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			fallCnt <= 5'h00;
			riseCnt <= 5'h00;
		end else if (csFallEv || restart) begin
			fallCnt <= 5'h00; // R15
			riseCnt <= 5'h00;
		end else begin
			if (fallEv && fallCnt != MAX_CLKS)
				fallCnt <= fallCnt + 5'h01; // R12
			if (riseEv && riseCnt != MAX_CLKS)
				riseCnt <= riseCnt + 5'h01;
		end
	end

	// address shifts in msb first on the opening rises
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			addrShift <= '0;
			chSel     <= '0;
		end else if (csFallEv) begin
			addrShift <= '0; // R15
		end else if (riseEv && riseCnt < ADDR_RISES) begin
			addrShift <= {addrShift[ADDR_W-3:0], adS}; // R14
			if (riseCnt == ADDR_RISES - 5'h01)
				chSel <= {addrShift, adS}; // R02
		end
	end

	// one-hot multiplexer select; upper three are the self tests
	genvar gi;
	generate
		for (gi = 0; gi < MUX_N; gi++) begin : g_dec
			always_ff @(posedge clk_sys) begin
				if (rst)
					muxSel[gi] <= 1'b0;
				else
					muxSel[gi] <= chSel == ADDR_W'(gi); // R16
			end
		end
	endgenerate

	// sampling window and the hand-off pulse to the conversion core
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sampling  <= 1'b0;
			convStart <= 1'b0;
		end else begin
			convStart <= tenthFall && !restart; // R04 R10
			if (csS || csFallEv || tenthFall)
				sampling <= 1'b0; // R03
			else if (fallEv && fallCnt == SAMPLE_FALL - 5'h01)
				sampling <= 1'b1; // R03
		end
	end

	// conversion progress; an 11th rise during a conversion makes it slow
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			convState <= CV_IDLE;
		end else begin
			unique case (convState)
				CV_IDLE: begin
					if (tenthFall && !restart)
						convState <= CV_BUSY; // R04
				end
				CV_BUSY: begin
					if (inS.valid && inS.ready)
						convState <= CV_IDLE; // R13
					else if (riseEv && riseCnt == SLOW_RISE - 5'h01)
						convState <= CV_SLOW; // R17
				end
				CV_SLOW: begin
					if (pop)
						convState <= CV_IDLE;
				end
			endcase
		end
	end

	// result latch; the held word is what every later fall reads from
	always_ff @(posedge clk_sys) begin
		if (rst)
			resHold <= '0;
		else if (pop)
			resHold <= outS.data; // R18
	end

	// serial output: msb on sequence start, then one bit per fall,
	// then zeros; the output keeps a level even while floated
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			dataOut <= 1'b0;
		end else if (pop) begin
			dataOut <= outS.data[RES_W-1]; // R08
		end else if (csFallEv) begin
			dataOut <= resHold[RES_W-1]; // R08
		end else if (fallEv) begin
			if (fallCnt <= {1'b0, LAST_SHIFT})
				dataOut <= nextBit; // R09
			else
				dataOut <= 1'b0; // R11
		end
	end

	// driver enabled only while the synchronised select is low
	always_ff @(posedge clk_sys) begin
		if (rst)
			dataOutEn <= 1'b0;
		else
			dataOutEn <= !csS; // R05 R06
	end

	// done flag: cleared by the tenth fall, set when the word is shown;
	// a showing word wins since it also restarts the sequence
	always_ff @(posedge clk_sys) begin
		if (rst)
			eoc <= EOC_RESET;
		else if (pop)
			eoc <= 1'b1; // R01
		else if (tenthFall)
			eoc <= 1'b0; // R01
	end

	// done flag follows the tenth fall and the shown result; the set
	// side wins when both land in one cycle
	a_eoc_tenth_low : assert property ( // R01
		tenthFall && !pop |=> !eoc)
		else $error("done flag not low after tenth fall");
	a_eoc_shown_high : assert property ( // R01
		pop |=> eoc && dataOut == $past(outS.data[RES_W-1]))
		else $error("done flag not high when result shown");

	// address capture, the sampling window and the conversion hand-off
	a_addr_capture : assert property ( // R02
		riseEv && riseCnt == 5'h03 && !csFallEv
		|=> chSel == {$past(addrShift), $past(adS)})
		else $error("address not captured on fourth rise");
	a_sample_window : assert property ( // R03
		fallEv && fallCnt == 5'h03 && !pop && !csFallEv |=> sampling)
		else $error("sampling window not opened");
	a_sample_hold : assert property ( // R03
		sampling && !tenthFall && !csS && !csFallEv |=> sampling)
		else $error("sampling window closed early");
	a_conv_handoff : assert property ( // R04
		tenthFall && !restart
		|=> convStart && !sampling && convState != CV_IDLE)
		else $error("conversion not handed off on tenth fall");

	// output driver and the shifted bits
	a_float_idle : assert property ( // R05
		csS |=> !dataOutEn ##1 (!dataOutEn || !csS))
		else $error("output driven while select high");
	a_cs_fall_msb : assert property ( // R06
		csFallEv && !pop |=> dataOutEn
		&& dataOut == $past(resHold[RES_W-1]) && fallCnt == 5'h00)
		else $error("select fall did not show msb");
	a_shift_bit : assert property ( // R09
		fallEv && fallCnt <= 5'h08 && !pop && !csFallEv
		|=> dataOut == $past(nextBit))
		else $error("wrong result bit shifted");
	a_zero_pad : assert property ( // R11
		fallEv && fallCnt >= 5'h09 && !pop && !csFallEv |=> !dataOut)
		else $error("pad bit not zero");

	// conversion start, slow hold, result latch and decode; the slow
	// hold keeps a late word from cutting bits still in flight
	a_no_early_conv : assert property ( // R10
		convStart |-> $past(fallCnt) == 5'h09 && $past(fallEv))
		else $error("conversion started before ten clocks");
	a_slow_holds : assert property ( // R13
		convState == CV_SLOW && !csS && fallCnt < MAX_CLKS |-> !pop)
		else $error("slow result shown mid transfer");
	a_result_latch : assert property ( // R18
		pop |=> resHold == $past(outS.data))
		else $error("result not latched");
	a_mid_ref_decode : assert property ( // R16
		chSel == ADDR_MID_REF |=> muxSel == 14'h0800)
		else $error("mid reference not selected");

	// main scenarios: mode 1 frame, restart with select low, slow
	// showing, a full buffer and a frame cut short
	c_mode1_done : cover property (fallEv && fallCnt == 5'h09
		##[1:300] csS);
	c_fast_restart : cover property (restart && convState == CV_IDLE);
	c_slow_show : cover property (pop && !csS && fallCnt == MAX_CLKS);
	c_buffer_full : cover property (coreValid && !coreReady);
	c_frame_cut : cover property (sampling && csS);
endmodule

// file: bench/host_port_model.sv
// host serial port model: select, shift clock, address, result read
`timescale 1ns/1ps
module host_port_model (
	input  wire logic clk_sys,
	input  wire logic dataOut,
	input  wire logic dataOutEn,
	output logic      csN,
	output logic      ioClk,
	output logic      addrIn
);
	logic lastBit = 1'b0; // last level seen on the data line
	logic lineLvl; // data line as the host sees it

	// a floating line has no pull: show a pattern that toggles each cycle
	always_comb lineLvl = dataOutEn ? dataOut : ~lastBit;

	// remember the line level for the float pattern
	always @(posedge clk_sys) lastBit <= lineLvl;

	// idle: deselected, shift clock parked low between frames
	initial begin
		csN = 1'b1;
		ioClk = 1'b0;
		addrIn = 1'b0;
	end

	// half a shift-clock period of 80 ns, all changes at falling edges
	task automatic half();
		repeat (4) @(negedge clk_sys);
	endtask

	// one burst of n clocks; sel pulls select low first if it is high
	task automatic burst(input logic [3:0] code, input int n,
		input bit sel, output logic [15:0] got);
		got = 16'h0000;
		if (sel && csN) begin
			csN = 1'b0;
			half();
		end
		for (int i = 0; i < n; i++) begin
			// address msb first, then junk that must be ignored
			addrIn = (i < 4) ? code[3 - i] : ~addrIn;
			half();
			ioClk = 1'b1;
			half();
			got[15 - i] = lineLvl;
			ioClk = 1'b0;
		end
		half();
	endtask

	// end of a frame: select goes high
	task automatic release_cs();
		csN = 1'b1;
		half();
	endtask
endmodule

// file: bench/test_serial_adc_control_port.sv
// self-checking bench for the converter serial control port
`timescale 1ns/1ps
module test_serial_adc_control_port;
	import adc_serial_pkg::*;
	logic             clk_sys;     // system clock
	logic             rst;         // synchronous reset
	logic             coreValid;   // core offers a result
	logic [RES_W-1:0] coreData;    // core result
	logic             coreReady;   // buffer has room
	logic             csN;         // select, active low
	logic             ioClk;       // shift clock
	logic             addrIn;      // serial address
	logic             dataOut;     // result bit
	logic             dataOutEn;   // result bit driven
	logic             eoc;         // conversion done
	logic [MUX_N-1:0] muxSel;      // channel select
	logic             sampling;    // sample window
	logic             convStart;   // convert pulse
	logic [15:0]      got;         // bits read by the host
	logic [RES_W-1:0] lastRes = 10'h2A5; // newest result taken
	logic             autoCore = 1'b1;   // core answers pulses
	int               convDelay = 200;   // core time in cycles
	int               failures = 0;
	int               check_count = 0;
	int               cnvCount = 0;      // convert pulses seen
	int               sampRun = 0;       // current window cycles
	int               sampLen = 0;       // last window cycles

	serial_adc_control_port dut (.clk_sys(clk_sys), .rst(rst), .csN(csN),
		.ioClk(ioClk), .addrIn(addrIn), .dataOut(dataOut),
		.dataOutEn(dataOutEn), .eoc(eoc), .muxSel(muxSel),
		.sampling(sampling), .convStart(convStart),
		.coreValid(coreValid), .coreData(coreData), .coreReady(coreReady));
	host_port_model host (.clk_sys(clk_sys), .dataOut(dataOut),
		.dataOutEn(dataOutEn), .csN(csN), .ioClk(ioClk), .addrIn(addrIn));

	// 100 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// count pulses and window lengths at settled falling edges
	always @(negedge clk_sys) begin
		if (convStart === 1'b1)
			cnvCount++;
		if (sampling === 1'b1)
			sampRun++;
		else begin
			if (sampRun != 0)
				sampLen = sampRun;
			sampRun = 0;
		end
	end

	task automatic check_word(input string what, input logic [15:0] exp,
		input logic [15:0] seen);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic check_flag(input string what, input logic exp,
		input logic seen);
		check_word(what, {15'h0000, exp}, {15'h0000, seen});
	endtask

	// hand one result to the port, held until it is taken
	task automatic offer(input logic [RES_W-1:0] w);
		coreData = w;
		coreValid = 1'b1;
		for (int k = 0; k < 400 && coreReady !== 1'b1; k++)
			@(negedge clk_sys);
		check_flag("core ready", 1'b1, coreReady);
		@(negedge clk_sys);
		coreValid = 1'b0;
		coreData = ~w;
		lastRes = w;
	endtask

	// conversion core: a fresh result convDelay cycles after each pulse
	initial forever begin
		@(negedge clk_sys);
		if (convStart === 1'b1 && autoCore) begin
			repeat (convDelay) @(negedge clk_sys);
			offer({lastRes[8:0], ~lastRes[9]});
		end
	end

	task automatic wait_eoc();
		for (int k = 0; k < 600 && eoc !== 1'b1; k++)
			@(negedge clk_sys);
		check_flag("eoc rise", 1'b1, eoc);
	endtask

	// one transfer: previous result back, one pulse, done flag as given
	task automatic xfer(input logic [3:0] code, input int n, input bit rel,
		input logic eocExp);
		logic [15:0] exp;
		int          cnt;
		exp = {lastRes, 6'h00};
		cnt = cnvCount;
		host.burst(code, n, 1'b1, got);
		check_word("data", exp, got);
		check_word("pulses", 16'(cnt + 1), 16'(cnvCount));
		check_flag("eoc", eocExp, eoc);
		if (rel) begin
			host.release_cs();
			check_flag("enable", 1'b0, dataOutEn);
		end
	endtask

	// deselected: clocks and address do nothing, line floats
	task automatic t_idle();
		logic [MUX_N-1:0] m;
		int               cnt;
		m = muxSel;
		cnt = cnvCount;
		host.burst(4'h5, 12, 1'b0, got);
		check_flag("idle enable", 1'b0, dataOutEn);
		check_flag("idle eoc", 1'b1, eoc);
		check_word("idle mux", 16'(m), 16'(muxSel));
		check_word("idle pulses", 16'(cnt), 16'(cnvCount));
	endtask

	// mode 1 over every address code
	task automatic t_codes();
		for (int c = 0; c < 16; c++) begin
			xfer(4'(c), 10, 1'b1, 1'b0);
			check_word("mux", c < MUX_N ? 16'(1) << c : 16'h0000,
				16'(muxSel));
			check_word("window", 16'h0030, 16'(sampLen));
			wait_eoc();
		end
	endtask

	// modes 3, 2 and 4, then slow modes 5 and 6
	task automatic t_modes();
		xfer(4'h2, 11, 1'b1, 1'b0);
		wait_eoc();
		xfer(4'h2, 16, 1'b1, 1'b0);
		wait_eoc();
		for (int n = 10; n <= 16; n += 6)
			repeat (2) begin
				xfer(4'h7, n, 1'b0, 1'b0);
				wait_eoc();
			end
		host.release_cs();
		convDelay = 40;
		xfer(4'h1, 12, 1'b1, 1'b0);
		wait_eoc();
		repeat (2)
			xfer(4'h1, 16, 1'b0, 1'b1);
		host.release_cs();
		convDelay = 200;
	endtask

	// nine clocks start nothing; the next frame starts clean
	task automatic t_abort();
		int cnt;
		cnt = cnvCount;
		host.burst(4'h3, 9, 1'b1, got);
		host.release_cs();
		check_word("short pulses", 16'(cnt), 16'(cnvCount));
		check_flag("short eoc", 1'b1, eoc);
		xfer(4'h6, 10, 1'b1, 1'b0);
		check_word("mux after abort", 16'h0040, 16'(muxSel));
		wait_eoc();
	endtask

	// two results queue during a frame; the buffer then refuses more
	task automatic t_buffer();
		autoCore = 1'b0;
		fork
			host.burst(4'h0, 10, 1'b1, got);
			begin
				repeat (12) @(negedge clk_sys);
				offer(10'h155);
				// let an edge pass so valid is not lowered and raised at once
				@(negedge clk_sys);
				offer(10'h0AA);
				repeat (2) @(negedge clk_sys);
				check_flag("full", 1'b0, coreReady);
			end
		join
		wait_eoc();
		lastRes = 10'h155;
		xfer(4'h0, 10, 1'b0, 1'b1);
		lastRes = 10'h0AA;
		xfer(4'h0, 10, 1'b0, 1'b0);
		offer(10'h3C3);
		autoCore = 1'b1;
		wait_eoc();
		host.release_cs();
	endtask

	task automatic complete_run();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// main sequence; the first frame only primes the result latch
	initial begin
		rst = 1'b1;
		coreValid = 1'b0;
		coreData = 10'h000;
		repeat (8) @(negedge clk_sys);
		rst = 1'b0;
		repeat (4) @(negedge clk_sys);
		t_idle();
		host.burst(4'h0, 10, 1'b1, got);
		host.release_cs();
		wait_eoc();
		t_codes();
		t_modes();
		t_abort();
		t_buffer();
		complete_run();
	end

	// hang guard, far above the expected run
	initial begin
		#1_000_000;
		failures++;
		complete_run();
	end
endmodule
